//--- common/hsc_params.svh
// Constants of the high speed capture port: offsets, fields, timing
`ifndef HSC_PARAMS_SVH
`define HSC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define HSC_CAPTURE_CFG_ADDR 16'hE706
`define HSC_PORT_LOCK_ADDR 16'hEC01
`define HSC_CAPTURE_CFG_RESET 8'h00
`define HSC_CAPTURE_CFG_MASK 8'h3F
`define HSC_PORT_LOCK_RESET 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HSC_CLKSEL_BIT 0
`define HSC_SIZE_BIT 1
`define HSC_GAP_BIT 2
`define HSC_XFER_LSB 3
`define HSC_XFER_MSB 4
`define HSC_POL_BIT 5
`define HSC_EXTREF_BIT 0
`define HSC_LOCK_BIT 1

// ----------------------------------------------------------------------
// Content select codes and burst shapes
// ----------------------------------------------------------------------
`define HSC_XFER_FULL 2'b00
`define HSC_XFER_WAVE 2'b01
`define HSC_XFER_POWER 2'b10
`define HSC_XFER_RSVD 2'b11
`define HSC_FULL_WORDS 5'h10
`define HSC_WAVE_WORDS 5'h07
`define HSC_POWER_WORDS 5'h09
`define HSC_POWER_START 4'h7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HSC_SYS_CLK_MHZ 125
`define HSC_FAST_CLK_MHZ 8
`define HSC_SLOW_CLK_MHZ 4
`define HSC_DIV_MOD 9'(`HSC_SYS_CLK_MHZ)
`define HSC_FAST_INC 9'(2 * `HSC_FAST_CLK_MHZ)
`define HSC_SLOW_INC 9'(2 * `HSC_SLOW_CLK_MHZ)
`define HSC_GAP_CYCLES 3'h7
`define HSC_SPI_TOGGLES 2'h3

`endif

//--- common/hsc_pkg.sv
// Types of the high speed capture port
package hsc_pkg;

	// ------------------------------------------------------------------
	// Streamed values from the metering core
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [31:0] phaseACurrentSample;
		logic [31:0] phaseAVoltageSample;
		logic [31:0] phaseBCurrentSample;
		logic [31:0] phaseBVoltageSample;
		logic [31:0] phaseCCurrentSample;
		logic [31:0] phaseCVoltageSample;
		logic [31:0] phaseAApparentPower;
		logic [31:0] phaseBApparentPower;
		logic [31:0] phaseCApparentPower;
		logic [31:0] phaseAActivePower;
		logic [31:0] phaseBActivePower;
		logic [31:0] phaseCActivePower;
		logic [31:0] phaseAReactivePower;
		logic [31:0] phaseBReactivePower;
		logic [31:0] phaseCReactivePower;
	} hsc_values_type;

	// One word in flight, marked when it closes the burst
	typedef struct packed {
		logic [31:0] data;
		logic last;
	} hsc_word_type;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_SHIFT = 2'b01,
		SER_GAP = 2'b10
	} hsc_ser_state_type;

	// Two-entry buffer state
	typedef struct packed {
		hsc_word_type [1:0] mem;
		logic wrPtr;
		logic rdPtr;
		logic [1:0] count;
	} hsc_buf_state_type;

	// Capture port state
	typedef struct packed {
		logic [7:0] captureCfg;
		logic externalRef;
		logic portLocked;
		logic spiActive;
		logic [1:0] toggleCnt;
		logic selSync1;
		logic selSync2;
		logic selPrev;
		logic [7:0] readData;
		logic readValid;
		hsc_values_type snapshot;
		logic [1:0] xfer;
		logic size8;
		logic gapEn;
		logic slowClk;
		logic seqBusy;
		logic [4:0] seqIdx;
		logic [8:0] divAcc;
		logic clkLevel;
		hsc_ser_state_type serState;
		logic [31:0] shiftReg;
		logic [4:0] bitCnt;
		logic wordLast;
		logic [2:0] gapCnt;
		logic burstActive;
		logic clkOut;
		logic dataOut;
		logic activePin;
	} hsc_state_type;

endpackage

//--- rtl/hsc_buffer.sv
// Two-entry word buffer between burst sequencer and serializer
`timescale 1ns/10ps
module hsc_buffer (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Filling side
	input wire logic inValid,
	input hsc_pkg::hsc_word_type inWord,
	output logic inReady,
	// Draining side
	output logic outValid,
	output hsc_pkg::hsc_word_type outWord,
	input wire logic outReady
);

	hsc_pkg::hsc_buf_state_type s;
	hsc_pkg::hsc_buf_state_type next_s;

	// Honest flags straight from the fill count
	assign inReady = (s.count != 2'h2);
	assign outValid = (s.count != 2'h0);
	assign outWord = s.mem[s.rdPtr];

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic push;
		logic pop;
		push = 1'b0;
		pop = 1'b0;
		next_s = s;
		push = inValid && inReady;
		pop = outReady && outValid;
		if (push) begin
			next_s.mem[s.wrPtr] = inWord;
			next_s.wrPtr = ~s.wrPtr;
		end
		if (pop) begin
			next_s.rdPtr = ~s.rdPtr;
		end
		if (push && !pop) begin
			next_s.count = s.count + 2'h1;
		end else if (pop && !push) begin
			next_s.count = s.count - 2'h1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule // hsc_buffer

//--- rtl/hsc_capture_port.sv
// High speed capture port framer with host port lock and reference select
//
// Overview of operation
// R1 - Capture clock 8 MHz or 4 MHz
// R2 - Size 0: whole 32-bit package, MSB first
// R3 - Size 1: four 8-bit packages, MSB first
// R4 - Gap enable inserts seven idle clock periods
// R5 - Code 00: sixteen words, samples, zero, powers
// R6 - Code 01: six samples then one zero
// R7 - Code 10: nine power words in order
// R8 - Code 11 behaves like code 00
// R9 - Bit 5 sets active pin polarity
// R10 - Unlocked: three select toggles enable SPI
// R11 - I2C locked by bit one, toggles ignored
// R12 - SPI active: any lock-register write locks
// R13 - Lock survives power mode changes
// R14 - Reference select: internal or external
// R15 - Reserved bits have no effect
// R16 - Active pin asserted across whole burst
`timescale 1ns/10ps
`include "hsc_params.svh"
module hsc_capture_port (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regAddr,
	input wire logic [7:0] regWriteData,
	output logic [7:0] regReadData,
	output logic regReadValid,
	// Values from the metering core
	input hsc_pkg::hsc_values_type values,
	input wire logic valuesStrobe,
	// Capture port pins
	output logic captureSerialClock,
	output logic captureSerialData,
	output logic transferActiveOutput,
	// Host port selection
	input wire logic selectOrCapturePin,
	output logic hostSpiSelect,
	output logic hostPortLocked,
	// Analog reference
	output logic externalReferenceEnable
);

	hsc_pkg::hsc_state_type s;
	hsc_pkg::hsc_state_type next_s;

	hsc_pkg::hsc_word_type bufInWord;
	hsc_pkg::hsc_word_type bufOutWord;
	logic bufInValid;
	logic bufInReady;
	logic bufOutValid;
	logic bufOutReady;

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	// Word at a position of the full burst; position 6 is the zero word
	function automatic logic [31:0] pickWord(
		input hsc_pkg::hsc_values_type v,
		input logic [3:0] pos
	);
		logic [31:0] w;
		w = 32'h00000000;
		case (pos)
			4'h0: w = v.phaseACurrentSample;
			4'h1: w = v.phaseAVoltageSample;
			4'h2: w = v.phaseBCurrentSample;
			4'h3: w = v.phaseBVoltageSample;
			4'h4: w = v.phaseCCurrentSample;
			4'h5: w = v.phaseCVoltageSample;
			4'h6: w = 32'h00000000;
			4'h7: w = v.phaseAApparentPower;
			4'h8: w = v.phaseBApparentPower;
			4'h9: w = v.phaseCApparentPower;
			4'hA: w = v.phaseAActivePower;
			4'hB: w = v.phaseBActivePower;
			4'hC: w = v.phaseCActivePower;
			4'hD: w = v.phaseAReactivePower;
			4'hE: w = v.phaseBReactivePower;
			default: w = v.phaseCReactivePower;
		endcase
		return w;
	endfunction

	// Number of words in a burst for a content code
	function automatic logic [4:0] burstLength(input logic [1:0] code);
		logic [4:0] n;
		n = `HSC_FULL_WORDS;
		if (code == `HSC_XFER_WAVE) begin
			n = `HSC_WAVE_WORDS; // R6
		end else if (code == `HSC_XFER_POWER) begin
			n = `HSC_POWER_WORDS; // R7
		end
		// Reserved code keeps the full length R8
		return n;
	endfunction

	// ------------------------------------------------------------------
	// Word buffer
	// ------------------------------------------------------------------
	// Absorbs the serializer's stall while the next word is fetched
	hsc_buffer hsc_buffer_inst (
		.clk(clk),
		.sys_rst(sys_rst),
		.inValid(bufInValid),
		.inWord(bufInWord),
		.inReady(bufInReady),
		.outValid(bufOutValid),
		.outWord(bufOutWord),
		.outReady(bufOutReady)
	);

	// Sequencer feeds the buffer while a burst is being fetched
	always_comb begin
		logic [3:0] pos;
		pos = 4'h0;
		pos = s.seqIdx[3:0];
		if (s.xfer == `HSC_XFER_POWER) begin
			pos = s.seqIdx[3:0] + `HSC_POWER_START; // R7
		end
		bufInValid = s.seqBusy;
		bufInWord.data = pickWord(s.snapshot, pos); // R5 R6
		bufInWord.last = (s.seqIdx == burstLength(s.xfer) - 5'h1);
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [8:0] accSum;
		logic toggle;
		logic fallTick;
		logic riseTick;
		logic wordDone;
		logic boundary;
		logic needGap;
		logic sendBit;
		logic loadWord;
		logic selEdge;
		accSum = 9'h000;
		toggle = 1'b0;
		fallTick = 1'b0;
		riseTick = 1'b0;
		wordDone = 1'b0;
		boundary = 1'b0;
		needGap = 1'b0;
		sendBit = 1'b0;
		loadWord = 1'b0;
		selEdge = 1'b0;
		bufOutReady = 1'b0;
		next_s = s;

		// Register writes; reserved bits never stored R15
		if (regWrite) begin
			if (regAddr == `HSC_CAPTURE_CFG_ADDR) begin
				next_s.captureCfg = regWriteData & `HSC_CAPTURE_CFG_MASK; // R15
			end else if (regAddr == `HSC_PORT_LOCK_ADDR) begin
				next_s.externalRef = regWriteData[`HSC_EXTREF_BIT]; // R14
				if (s.spiActive) begin
					next_s.portLocked = 1'b1; // R12
				end else if (regWriteData[`HSC_LOCK_BIT]) begin
					next_s.portLocked = 1'b1; // R11
				end
			end
		end

		// Register reads answer one cycle later; unmapped reads zero
		next_s.readValid = regRead;
		if (regRead) begin
			if (regAddr == `HSC_CAPTURE_CFG_ADDR) begin
				next_s.readData = s.captureCfg;
			end else if (regAddr == `HSC_PORT_LOCK_ADDR) begin
				next_s.readData = {6'h00, s.portLocked, s.externalRef};
			end else begin
				next_s.readData = 8'h00;
			end
		end

		// Select pin synchronizer and toggle counter
		next_s.selSync1 = selectOrCapturePin;
		next_s.selSync2 = s.selSync1;
		next_s.selPrev = s.selSync2;
		selEdge = s.selSync2 ^ s.selPrev;
		// Lock is never cleared except by reset, so power modes keep it R13
		if (selEdge && !s.portLocked && !s.spiActive) begin // R10 R11
			next_s.toggleCnt = s.toggleCnt + 2'h1;
			if (s.toggleCnt == `HSC_SPI_TOGGLES - 2'h1) begin
				next_s.spiActive = 1'b1; // R10
			end
		end

		// Fractional divider: exact average rate from 125 MHz R1
		accSum = s.divAcc + (s.slowClk ? `HSC_SLOW_INC : `HSC_FAST_INC);
		if (accSum >= `HSC_DIV_MOD) begin
			next_s.divAcc = accSum - `HSC_DIV_MOD;
			toggle = 1'b1;
		end else begin
			next_s.divAcc = accSum;
		end
		if (toggle) begin
			next_s.clkLevel = ~s.clkLevel;
		end
		fallTick = toggle && s.clkLevel;
		riseTick = toggle && !s.clkLevel;

		// Burst start: snapshot values and framing settings together
		if (valuesStrobe && !s.burstActive && !s.seqBusy) begin
			next_s.snapshot = values;
			next_s.xfer = s.captureCfg[`HSC_XFER_MSB:`HSC_XFER_LSB];
			next_s.size8 = s.captureCfg[`HSC_SIZE_BIT];
			next_s.gapEn = s.captureCfg[`HSC_GAP_BIT];
			next_s.slowClk = s.captureCfg[`HSC_CLKSEL_BIT]; // R1
			next_s.seqBusy = 1'b1;
			next_s.seqIdx = 5'h00;
			next_s.burstActive = 1'b1; // R16
		end

		// Sequencer advances on each accepted word
		if (bufInValid && bufInReady) begin
			next_s.seqIdx = s.seqIdx + 5'h01;
			if (bufInWord.last) begin
				next_s.seqBusy = 1'b0;
			end
		end

		// Serializer works on falling edges of the capture clock
		wordDone = (s.bitCnt == 5'h00);
		if (s.size8) begin
			boundary = (s.bitCnt[2:0] == 3'h0); // R3
		end else begin
			boundary = wordDone; // R2
		end
		needGap = s.gapEn && boundary && !(wordDone && s.wordLast); // R4
		if (fallTick) begin
			case (s.serState)
				hsc_pkg::SER_IDLE: begin
					loadWord = 1'b1;
				end
				hsc_pkg::SER_SHIFT: begin
					if (needGap) begin
						next_s.serState = hsc_pkg::SER_GAP;
						next_s.gapCnt = 3'h1;
					end else if (wordDone) begin
						loadWord = 1'b1;
					end else begin
						sendBit = 1'b1;
					end
				end
				hsc_pkg::SER_GAP: begin
					if (s.gapCnt == `HSC_GAP_CYCLES) begin // R4
						next_s.serState = hsc_pkg::SER_SHIFT;
						if (wordDone) begin
							loadWord = 1'b1;
						end else begin
							sendBit = 1'b1;
						end
					end else begin
						next_s.gapCnt = s.gapCnt + 3'h1;
					end
				end
				default: begin
					next_s.serState = hsc_pkg::SER_IDLE;
				end
			endcase
		end

		// Load the next word, or close the burst when none remains
		if (loadWord) begin
			if (bufOutValid) begin
				bufOutReady = 1'b1;
				next_s.serState = hsc_pkg::SER_SHIFT;
				next_s.dataOut = bufOutWord.data[31]; // R2 R3
				next_s.shiftReg = {bufOutWord.data[30:0], 1'b0};
				next_s.bitCnt = 5'h01;
				next_s.wordLast = bufOutWord.last;
				next_s.clkOut = 1'b0;
			end else begin
				next_s.serState = hsc_pkg::SER_IDLE;
				if ((s.serState != hsc_pkg::SER_IDLE && s.wordLast) ||
						(s.burstActive && !s.seqBusy)) begin
					next_s.burstActive = 1'b0; // R16
				end
			end
		end

		// Next bit, most significant first
		if (sendBit) begin
			next_s.dataOut = s.shiftReg[31]; // R2 R3
			next_s.shiftReg = {s.shiftReg[30:0], 1'b0};
			next_s.bitCnt = s.bitCnt + 5'h01;
			next_s.clkOut = 1'b0;
		end

		// Clock idles high; only data periods pulse it low
		if (riseTick) begin
			next_s.clkOut = 1'b1;
		end

		// Polarity follows the live register bit R9
		if (next_s.captureCfg[`HSC_POL_BIT]) begin
			next_s.activePin = next_s.burstActive; // R9
		end else begin
			next_s.activePin = ~next_s.burstActive; // R9
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s <= '0;
			s.captureCfg <= `HSC_CAPTURE_CFG_RESET;
			s.externalRef <= 1'(`HSC_PORT_LOCK_RESET >> `HSC_EXTREF_BIT);
			// Select pin idles high; a low reset value gave a false toggle
			s.selSync1 <= 1'b1;
			s.selSync2 <= 1'b1;
			s.selPrev <= 1'b1;
			s.clkOut <= 1'b1;
			s.activePin <= 1'b1;
			s.serState <= hsc_pkg::SER_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from flip-flops
	assign regReadData = s.readData;
	assign regReadValid = s.readValid;
	assign captureSerialClock = s.clkOut;
	assign captureSerialData = s.dataOut;
	assign transferActiveOutput = s.activePin;
	assign hostSpiSelect = s.spiActive;
	assign hostPortLocked = s.portLocked;
	assign externalReferenceEnable = s.externalRef; // R14

endmodule // hsc_capture_port

//--- testbench/hsc_capture_port_properties.sv
// Port-level properties of the capture port
`timescale 1ns/10ps
`include "hsc_params.svh"
module hsc_capture_port_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic regReadValid,
	// Stream and host pins
	input wire logic valuesStrobe,
	input wire logic captureSerialClock,
	input wire logic captureSerialData,
	input wire logic transferActiveOutput,
	input wire logic hostSpiSelect,
	input wire logic hostPortLocked,
	input wire logic externalReferenceEnable
);
	// ------
	// Helpers
	// ------
	logic polCfg;
	logic act;
	logic lockWr;
	// Pin takes a new polarity at the very edge that stores the write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			polCfg <= 1'b0;
		end else begin
			if (regWrite && regAddr == `HSC_CAPTURE_CFG_ADDR)
				polCfg <= regWriteData[`HSC_POL_BIT];
		end
	end
	assign act = (transferActiveOutput == polCfg);
	assign lockWr = regWrite && regAddr == `HSC_PORT_LOCK_ADDR;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ------
	// Assertions
	// ------
	chk_active_start: assert property (valuesStrobe && !act |=> act)
		else $error("active pin not raised by strobe");
	chk_clock_idle: assert property (!act |-> captureSerialClock)
		else $error("capture clock low outside burst");
	chk_low_half: assert property ($fell(captureSerialClock) |->
		!captureSerialClock [*7] ##[1:10] captureSerialClock)
		else $error("capture clock low half wrong");
	chk_high_half: assert property ($rose(captureSerialClock) && act |->
		captureSerialClock [*7])
		else $error("capture clock high half short");
	chk_data_steady: assert property (!captureSerialClock &&
		!$past(captureSerialClock) |-> $stable(captureSerialData))
		else $error("data moved while clock low");
	chk_spi_unlocked: assert property ($rose(hostSpiSelect) |->
		!$past(hostPortLocked))
		else $error("SPI selected while locked");
	chk_lock_sticky: assert property (hostPortLocked |=> hostPortLocked)
		else $error("lock dropped");
	chk_spi_sticky: assert property (hostSpiSelect |=> hostSpiSelect)
		else $error("SPI choice dropped");
	chk_spi_lock: assert property (lockWr && hostSpiSelect |=> ##[0:1]
		hostPortLocked)
		else $error("SPI not locked by write");
	chk_i2c_lock: assert property (lockWr && regWriteData[`HSC_LOCK_BIT]
		|=> ##[0:1] hostPortLocked)
		else $error("lock bit write did not lock");
	chk_ext_ref: assert property (lockWr |=> ##[0:1] externalReferenceEnable
		== regWriteData[`HSC_EXTREF_BIT])
		else $error("reference select wrong");
	chk_read_answer: assert property (regRead |=> ##[0:1] regReadValid)
		else $error("read not answered");
endmodule // hsc_capture_port_properties

//--- testbench/hsc_receiver_model.sv
// Behavioural receiver at the far end of the capture stream
`timescale 1ns/10ps
module hsc_receiver_model (
	// Clock
	input wire logic clk,
	// Capture pins
	input wire logic sck,
	input wire logic sdata,
	input wire logic activePin,
	input wire logic pol
);
	logic [31:0] words [0:15];
	logic [31:0] shiftIn;
	logic sckDly = 1'b1;
	logic actDly = 1'b0;
	int numWords = 0;
	int bitCnt = 0;
	int run = 0;
	int maxLow = 0;
	int gaps = 0;
	// Oversampled by the system clock; long high runs count as gaps
	always @(posedge clk) begin
		if (activePin === pol && !actDly) begin
			numWords = 0;
			bitCnt = 0;
			run = 0;
			maxLow = 0;
			gaps = 0;
		end else if (activePin === pol) begin
			if (sck === sckDly) begin
				run++;
			end else begin
				if (!sckDly && run > maxLow)
					maxLow = run;
				if (sckDly && run > 40)
					gaps++;
				run = 1;
			end
			// Data settles at the falling edge, taken at the rising
			if (sck && !sckDly) begin
				shiftIn = {shiftIn[30:0], sdata};
				bitCnt++;
				if (bitCnt == 32) begin
					if (numWords < 16)
						words[numWords] = shiftIn;
					numWords++;
					bitCnt = 0;
				end
			end
		end
		sckDly = sck;
		actDly = (activePin === pol);
	end
endmodule // hsc_receiver_model

//--- testbench/hsc_capture_port_tb.sv
// Testbench of the capture port with receiver model
`timescale 1ns/10ps
`include "hsc_params.svh"
module hsc_capture_port_tb;
	// ------
	// Signals
	// ------
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [15:0] regAddr = 16'h0000;
	logic [7:0] regWriteData = 8'h00;
	logic [7:0] regReadData;
	logic regReadValid;
	hsc_pkg::hsc_values_type values;
	logic valuesStrobe = 1'b0;
	logic captureSerialClock;
	logic captureSerialData;
	logic transferActiveOutput;
	logic selectOrCapturePin = 1'b1;
	logic hostSpiSelect;
	logic hostPortLocked;
	logic externalReferenceEnable;
	logic pol = 1'b0;
	int num_errors = 0;
	int total_checks = 0;
	// 125 MHz
	always #4 clk = ~clk;
	hsc_capture_port hsc_capture_port_inst (.*);
	hsc_receiver_model hsc_receiver_model_inst (.clk(clk),
		.sck(captureSerialClock), .sdata(captureSerialData),
		.activePin(transferActiveOutput), .pol(pol));
	// Distinct, bit-asymmetric words; slot 6 is the zero word
	function automatic logic [31:0] expw(input int s);
		return (s == 6) ? 32'h00000000 : 32'hB4C39E10 + 32'(s);
	endfunction
	initial begin
		for (int k = 0; k < 15; k++)
			values[(14 - k) * 32 +: 32] = expw(k < 6 ? k : k + 1);
	end
	// ------
	// Tasks
	// ------
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t data %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWriteData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		int n;
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		n = 0;
		#1;
		while (regReadValid !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp_flag(regReadValid, 1'b1);
		d = regReadData;
	endtask
	task automatic toggle3();
		repeat (3) begin
			repeat (8) @(posedge clk);
			selectOrCapturePin <= ~selectOrCapturePin;
		end
		repeat (12) @(posedge clk);
		#1;
	endtask
	// One burst with a strobe thrown in mid-burst, which must be ignored
	task automatic burst(input logic [7:0] cfg);
		int n;
		int cnt;
		int first;
		int lo;
		logic p;
		p = cfg[`HSC_POL_BIT];
		wr(`HSC_CAPTURE_CFG_ADDR, cfg);
		pol <= p;
		repeat (3) @(posedge clk);
		#1;
		cmp_flag(transferActiveOutput, !p);
		@(posedge clk);
		valuesStrobe <= 1'b1;
		@(posedge clk);
		valuesStrobe <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		cmp_flag(transferActiveOutput, p);
		repeat (100) @(posedge clk);
		valuesStrobe <= 1'b1;
		@(posedge clk);
		valuesStrobe <= 1'b0;
		n = 0;
		while (transferActiveOutput === p && n < 40000) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp_flag(transferActiveOutput, !p);
		cnt = cfg[4:3] == 2'b01 ? 7 : (cfg[4:3] == 2'b10 ? 9 : 16);
		first = cfg[4:3] == 2'b10 ? 7 : 0;
		cmp_data(hsc_receiver_model_inst.numWords, cnt);
		for (int i = 0; i < cnt; i++)
			cmp_data(hsc_receiver_model_inst.words[i], expw(first + i));
		n = cfg[2] ? (cfg[1] ? cnt * 4 - 1 : cnt - 1) : 0;
		cmp_data(hsc_receiver_model_inst.gaps, n);
		lo = cfg[0] ? 15 : 7;
		n = hsc_receiver_model_inst.maxLow;
		cmp_flag(n >= lo && n <= lo + 1, 1'b1);
	endtask
	// ------
	// Sequence
	// ------
	initial begin
		logic [7:0] d;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`HSC_CAPTURE_CFG_ADDR, d);
		cmp_data(d, `HSC_CAPTURE_CFG_RESET);
		wr(`HSC_CAPTURE_CFG_ADDR, 8'hFF);
		rd(`HSC_CAPTURE_CFG_ADDR, d);
		cmp_data(d, 8'h3F);
		rd(16'h1234, d);
		cmp_data(d, 8'h00);
		burst(8'h00);
		burst(8'h2F);
		burst(8'h14);
		burst(8'hDA);
		toggle3();
		cmp_flag(hostSpiSelect, 1'b1);
		wr(`HSC_PORT_LOCK_ADDR, 8'h00);
		rd(`HSC_PORT_LOCK_ADDR, d);
		cmp_flag(hostPortLocked, 1'b1);
		cmp_data(d, 8'h02);
		// Second reset, then the I2C path
		@(posedge clk);
		sys_rst <= 1'b1;
		selectOrCapturePin <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		wr(`HSC_PORT_LOCK_ADDR, 8'hFD);
		rd(`HSC_PORT_LOCK_ADDR, d);
		cmp_data(d, 8'h01);
		cmp_flag(externalReferenceEnable, 1'b1);
		cmp_flag(hostPortLocked, 1'b0);
		wr(`HSC_PORT_LOCK_ADDR, 8'h02);
		rd(`HSC_PORT_LOCK_ADDR, d);
		cmp_data(d, 8'h02);
		cmp_flag(externalReferenceEnable, 1'b0);
		toggle3();
		cmp_flag(hostSpiSelect, 1'b0);
		end_sim();
	end
	// Watchdog well past the longest expected run
	initial begin
		repeat (80000) @(posedge clk);
		num_errors++;
		end_sim();
	end
endmodule // hsc_capture_port_tb
bind hsc_capture_port hsc_capture_port_properties
	hsc_capture_port_properties_inst (.clk, .sys_rst, .regWrite, .regRead,
	.regAddr, .regWriteData, .regReadValid, .valuesStrobe,
	.captureSerialClock, .captureSerialData, .transferActiveOutput,
	.hostSpiSelect, .hostPortLocked, .externalReferenceEnable);
